// [vfe_pkg.sv]
// Constants and types of the video front end and sync generator.
// Assumes one main clock for configuration and a double-rate video clock.
//
// Overview of operation
// - Sampling of a line starts at pixel count first_pixel_offset after line sync.
// - Inputs latch on every other double-rate rising edge, chosen by the qualifier.
// - Sampling of a line stops after pixel count last_pixel_offset.
// - external_field_flag picks field_id_input or field derived from sync timing.
// - Line sync polarity 1 counts horizontal offsets from the falling edge.
// - Frame sync polarity 1 counts vertical offsets from the falling edge.
// - External field: top_field_sense 1 means field input high is top.
// - Internal field: line sync level at frame sync edge, compared with sense.
// - Qualifier polarity selects edges where qualifier clock is high or low.
// - Internal sync mode drives both generated syncs out.
// - Generated syncs use the same polarity settings as sampling.
// - Generated frames last frame_line_total lines.
// - Generated lines last line_clock_total pixel clocks.
// - Generated frame sync stays active frame_sync_length lines.
// - Generated line sync asserts at position line_sync_start.
// - Generated syncs change on qualified falling double-rate edges.
// - Odd fields put frame sync edges mid inactive line sync.
// - Even fields put frame sync edges mid active line sync.
// - Motion compression keeps codec output enable off.
// - Motion decompression: pixels from codec, sync internal or external.
// - Still compression drives pixels and syncs, codec output off.
// - Still decompression drives syncs, pixels come from the codec.
// - Processed area skips then covers active pixels and lines.
// - first_field_type 1 starts on odd field, 0 on even.
// - Start pulse issued at a field boundary of the requested type.

package vfe_pkg;

    localparam int VFE_CW = 10;
    localparam int VFE_HS_WIDTH = 64;
    localparam logic VFE_TOP_SENSE_RST = 1'b1;

    // ***************************************
    // Modes and start sequencing
    // ***************************************
    typedef enum logic [1:0] {
        VFE_MOTION_COMP = 2'h0,
        VFE_MOTION_DECOMP = 2'h1,
        VFE_STILL_COMP = 2'h2,
        VFE_STILL_DECOMP = 2'h3
    } vfe_mode_t;

    typedef enum logic [1:0] {
        VFE_ST_IDLE = 2'h0,
        VFE_ST_ARMED = 2'h1,
        VFE_ST_RUN = 2'h3
    } vfe_state_t;

    // ***************************************
    // Carriers
    // ***************************************
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] uv;
    } vfe_pix_t;

    typedef struct packed {
        logic [VFE_CW-1:0] first_pixel_offset;
        logic [VFE_CW-1:0] last_pixel_offset;
        logic [VFE_CW-1:0] first_line_offset;
        logic [VFE_CW-1:0] last_line_offset;
        logic [VFE_CW-1:0] skip_pixels;
        logic [VFE_CW-1:0] active_pixels;
        logic [VFE_CW-1:0] skip_lines;
        logic [VFE_CW-1:0] active_lines;
        logic [VFE_CW-1:0] frame_line_total;
        logic [VFE_CW-1:0] line_clock_total;
        logic [VFE_CW-1:0] frame_sync_length;
        logic [VFE_CW-1:0] line_sync_start;
        logic external_field_flag;
        logic line_sync_polarity;
        logic frame_sync_polarity;
        logic top_field_sense;
        logic qualifier_polarity;
        logic first_field_type;
        logic internal_sync;
        logic start_request;
        vfe_mode_t mode;
    } vfe_cfg_t;

endpackage

// [vfe_front_end.sv]
// Video front end: qualified sampling, field detection, sync generator.
// Configuration is quasi-static on mclk; pins belong to the video clock.

`timescale 1ns/10ps
`default_nettype none

module vfe_front_end #(
    parameter int HS_WIDTH = vfe_pkg::VFE_HS_WIDTH
) (
    // Clocks and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic double_rate_clock,
    // Configuration, mclk domain
    input wire vfe_pkg::vfe_cfg_t cfg,
    input wire vfe_pkg::vfe_pix_t still_pixel,
    // Video pins
    input wire logic pixel_qualifier_clock,
    input wire logic field_id_input,
    input wire vfe_pkg::vfe_pix_t pix_in,
    output var vfe_pkg::vfe_pix_t pix_out,
    output logic pix_oe,
    input wire logic hsync_in,
    input wire logic vsync_in,
    output logic hsync_out,
    output logic vsync_out,
    output logic sync_oe,
    output logic codec_output_enable,
    // Sampled stream, double_rate_clock domain
    output var vfe_pkg::vfe_pix_t sample_data,
    output logic sample_valid,
    output logic sample_active,
    output logic field_top,
    output logic start_pulse,
    // Status, mclk domain
    output logic field_top_status,
    output logic start_seen
);
    import vfe_pkg::*;

    // ***************************************
    // Parameter check
    // ***************************************
    if (HS_WIDTH < 2 || HS_WIDTH > 1000)
    begin : g_bad
        $error("HS_WIDTH out of range");
    end

    localparam logic [VFE_CW:0] HSW = (VFE_CW+1)'(HS_WIDTH);

    // ***************************************
    // Video domain state
    // ***************************************
    typedef struct packed {
        vfe_cfg_t cfg_a;
        vfe_cfg_t cfg_b;
        vfe_pix_t stl_a;
        vfe_pix_t stl_b;
        vfe_pix_t pix_a;
        vfe_pix_t pix_b;
        logic q_a;
        logic q_b;
        logic hs_a;
        logic hs_b;
        logic vs_a;
        logic vs_b;
        logic fi_a;
        logic fi_b;
        logic hs_prev;
        logic vs_prev;
        logic [VFE_CW-1:0] pcnt;
        logic [VFE_CW-1:0] lcnt;
        logic [VFE_CW-1:0] gh;
        logic [VFE_CW-1:0] gv;
        logic ghs;
        logic gvs;
        logic top;
        vfe_state_t st;
        vfe_pix_t data;
        logic valid;
        logic active;
        logic start;
        logic tgl;
    } vfe_vstate_t;

    typedef struct packed {
        logic f_a;
        logic f_b;
        logic t_a;
        logic t_b;
        logic t_c;
    } vfe_mstate_t;

    vfe_vstate_t r;
    vfe_vstate_t next_r;
    vfe_mstate_t m;
    vfe_mstate_t next_m;
    vfe_cfg_t c;
    logic ph;
    logic isync;
    logic hs_lvl;
    logic vs_lvl;
    logic hs_edge;
    logic vs_edge;
    logic new_top;
    logic win_h;
    logic win_v;
    logic [VFE_CW:0] end_h;
    logic [VFE_CW:0] end_v;
    logic [VFE_CW:0] mid_act;
    logic [VFE_CW:0] mid_in;
    logic [VFE_CW:0] half;
    logic v_on;
    logic v_off;
    logic hs_drv;
    logic vs_drv;
    logic [VFE_CW-1:0] cur_p;
    logic [VFE_CW-1:0] cur_l;

    function automatic logic in_rng(input logic [VFE_CW-1:0] v,
                                    input logic [VFE_CW:0] lo,
                                    input logic [VFE_CW:0] hi);
        in_rng = ({1'b0, v} >= lo) && ({1'b0, v} < hi);
    endfunction

    // ***************************************
    // Video domain next state
    // ***************************************
    always_comb
    begin
        next_r = r;
        c = r.cfg_b;
        next_r.cfg_a = cfg;
        next_r.cfg_b = r.cfg_a;
        next_r.stl_a = still_pixel;
        next_r.stl_b = r.stl_a;
        next_r.pix_a = pix_in;
        next_r.pix_b = r.pix_a;
        next_r.q_a = pixel_qualifier_clock;
        next_r.q_b = r.q_a;
        next_r.hs_a = hsync_in;
        next_r.hs_b = r.hs_a;
        next_r.vs_a = vsync_in;
        next_r.vs_b = r.vs_a;
        next_r.fi_a = field_id_input;
        next_r.fi_b = r.fi_a;
        next_r.valid = 1'b0;
        next_r.start = 1'b0;
        ph = (r.q_b == c.qualifier_polarity);
        isync = (c.mode == VFE_STILL_COMP) || (c.mode == VFE_STILL_DECOMP)
            || ((c.mode == VFE_MOTION_DECOMP) && c.internal_sync);
        // Own syncs are watched internally, so pins need not loop back
        hs_lvl = isync ? (r.ghs ^ c.line_sync_polarity) : r.hs_b;
        vs_lvl = isync ? (r.gvs ^ c.frame_sync_polarity) : r.vs_b;
        hs_edge = ph && (hs_lvl != r.hs_prev)
            && (hs_lvl == !c.line_sync_polarity);
        vs_edge = ph && (vs_lvl != r.vs_prev)
            && (vs_lvl == !c.frame_sync_polarity);
        if (c.external_field_flag)
        begin
            new_top = (r.fi_b == c.top_field_sense);
        end
        else
        begin
            new_top = (hs_lvl == c.top_field_sense);
        end
        // Count of the pixel now at the pipe end; the edge pixel is count zero
        cur_p = r.pcnt;
        cur_l = r.lcnt;
        // Counters saturate so a missing sync cannot wrap into the window
        if (hs_edge)
        begin
            cur_p = '0;
        end
        else if (ph && r.pcnt != '1)
        begin
            cur_p = r.pcnt + 1'b1;
        end
        if (vs_edge)
        begin
            cur_l = '0;
        end
        else if (hs_edge && r.lcnt != '1)
        begin
            cur_l = r.lcnt + 1'b1;
        end
        win_h = (cur_p >= c.first_pixel_offset) && (cur_p <= c.last_pixel_offset);
        win_v = (cur_l >= c.first_line_offset) && (cur_l <= c.last_line_offset);
        end_h = {1'b0, c.skip_pixels} + {1'b0, c.active_pixels};
        end_v = {1'b0, c.skip_lines} + {1'b0, c.active_lines};
        // Generator midpoints; assumes line_sync_start plus width fits the line
        mid_act = {1'b0, c.line_sync_start} + (HSW >> 1);
        mid_in = {1'b0, c.line_sync_start} + HSW
            + (({1'b0, c.line_clock_total} - HSW) >> 1);
        if (mid_in >= {1'b0, c.line_clock_total})
        begin
            mid_in = mid_in - {1'b0, c.line_clock_total};
        end
        half = {2'h0, c.frame_line_total[VFE_CW-1:1]};
        v_on = (({1'b0, r.gh} == mid_in) && (r.gv == '0))
            || (({1'b0, r.gh} == mid_act) && ({1'b0, r.gv} == half));
        v_off = (({1'b0, r.gh} == mid_in)
            && ({1'b0, r.gv} == {1'b0, c.frame_sync_length}))
            || (({1'b0, r.gh} == mid_act)
            && ({1'b0, r.gv} == half + {1'b0, c.frame_sync_length}));
        if (ph)
        begin
            next_r.hs_prev = hs_lvl;
            next_r.vs_prev = vs_lvl;
            next_r.pcnt = cur_p;
            next_r.lcnt = cur_l;
            if (win_h && win_v)
            begin
                next_r.data = r.pix_b;
                next_r.valid = 1'b1;
            end
            next_r.active = in_rng(cur_p, {1'b0, c.skip_pixels}, end_h)
                && in_rng(cur_l, {1'b0, c.skip_lines}, end_v);
            if (c.external_field_flag || vs_edge)
            begin
                next_r.top = new_top;
            end
            // Line and frame generator
            if ({1'b0, r.gh} >= {1'b0, c.line_clock_total} - 11'h001)
            begin
                next_r.gh = '0;
                if ({1'b0, r.gv} >= {1'b0, c.frame_line_total} - 11'h001)
                begin
                    next_r.gv = '0;
                end
                else
                begin
                    next_r.gv = r.gv + 1'b1;
                end
            end
            else
            begin
                next_r.gh = r.gh + 1'b1;
            end
            next_r.ghs = in_rng(r.gh, {1'b0, c.line_sync_start},
                {1'b0, c.line_sync_start} + HSW);
            if (v_on)
            begin
                next_r.gvs = 1'b1;
            end
            else if (v_off)
            begin
                next_r.gvs = 1'b0;
            end
            // Start sequencing; top field is treated as the odd field
            case (r.st)
                VFE_ST_IDLE:
                begin
                    if (c.start_request)
                    begin
                        next_r.st = VFE_ST_ARMED;
                    end
                end
                VFE_ST_ARMED:
                begin
                    if (!c.start_request)
                    begin
                        next_r.st = VFE_ST_IDLE;
                    end
                    else if (vs_edge && (new_top == c.first_field_type))
                    begin
                        next_r.start = 1'b1;
                        next_r.tgl = !r.tgl;
                        next_r.st = VFE_ST_RUN;
                    end
                end
                default:
                begin
                    if (!c.start_request)
                    begin
                        next_r.st = VFE_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge double_rate_clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.cfg_a.top_field_sense <= VFE_TOP_SENSE_RST;
            r.cfg_b.top_field_sense <= VFE_TOP_SENSE_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ***************************************
    // Sync drive on falling edges
    // ***************************************
    // Half a cycle of margin toward sampling devices on the same bus
    always_ff @(negedge double_rate_clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hs_drv <= 1'b1;
            vs_drv <= 1'b1;
        end
        else if (r.q_b == r.cfg_b.qualifier_polarity)
        begin
            hs_drv <= r.ghs ^ r.cfg_b.line_sync_polarity;
            vs_drv <= r.gvs ^ r.cfg_b.frame_sync_polarity;
        end
    end

    // ***************************************
    // Bus ownership per mode
    // ***************************************
    assign hsync_out = hs_drv;
    assign vsync_out = vs_drv;
    assign sync_oe = isync;
    assign pix_oe = (c.mode == VFE_STILL_COMP);
    assign pix_out = r.stl_b;
    assign codec_output_enable = (c.mode == VFE_MOTION_DECOMP)
        || (c.mode == VFE_STILL_DECOMP);
    assign sample_data = r.data;
    assign sample_valid = r.valid;
    assign sample_active = r.active;
    assign field_top = r.top;
    assign start_pulse = r.start;

    // ***************************************
    // Status crossing to mclk
    // ***************************************
    always_comb
    begin
        next_m.f_a = r.top;
        next_m.f_b = m.f_a;
        next_m.t_a = r.tgl;
        next_m.t_b = m.t_a;
        next_m.t_c = m.t_b;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            m <= '0;
        end
        else
        begin
            m <= next_m;
        end
    end

    assign field_top_status = m.f_b;
    assign start_seen = m.t_b ^ m.t_c;

    // ***************************************
    // Checks
    // ***************************************
    property p_window;
        @(posedge double_rate_clock) disable iff (!reset_n)
        r.valid |-> $past(ph && win_h && win_v);
    endproperty
    a_window: assert property (p_window) else $error("sample outside window");

    property p_alt;
        @(posedge double_rate_clock) disable iff (!reset_n)
        r.valid |=> !r.valid;
    endproperty
    a_alt: assert property (p_alt) else $error("samples on adjacent edges");

    property p_hreset;
        @(posedge double_rate_clock) disable iff (!reset_n)
        hs_edge |=> (r.pcnt == '0);
    endproperty
    a_hreset: assert property (p_hreset) else $error("pixel count not cleared");

    property p_line;
        @(posedge double_rate_clock) disable iff (!reset_n)
        ph && (r.gh == c.line_clock_total - 10'h001) |=> (r.gh == '0);
    endproperty
    a_line: assert property (p_line) else $error("line length wrong");

    property p_frame;
        @(posedge double_rate_clock) disable iff (!reset_n)
        ph && (r.gh == c.line_clock_total - 10'h001)
            && (r.gv == c.frame_line_total - 10'h001) |=> (r.gv == '0);
    endproperty
    a_frame: assert property (p_frame) else $error("frame length wrong");

    property p_vson;
        @(posedge double_rate_clock) disable iff (!reset_n)
        ph && v_on |=> r.gvs;
    endproperty
    a_vson: assert property (p_vson) else $error("frame sync not set");

    property p_mcomp;
        @(posedge double_rate_clock) disable iff (!reset_n)
        (c.mode == VFE_MOTION_COMP) |-> !codec_output_enable && !sync_oe && !pix_oe;
    endproperty
    a_mcomp: assert property (p_mcomp) else $error("bus driven in motion comp");

    property p_scomp;
        @(posedge double_rate_clock) disable iff (!reset_n)
        (c.mode == VFE_STILL_COMP) |-> pix_oe && sync_oe && !codec_output_enable;
    endproperty
    a_scomp: assert property (p_scomp) else $error("still comp ownership");

    property p_start;
        @(posedge double_rate_clock) disable iff (!reset_n)
        r.start |-> $past(vs_edge && r.st == VFE_ST_ARMED)
            && (r.top == $past(c.first_field_type));
    endproperty
    a_start: assert property (p_start) else $error("start at wrong field");

endmodule

`default_nettype wire

// [vfe_video_src.sv]
// Video source and codec model on the front end's pins.
// Assumes the bench supplies the double-rate clock; small frame sizes.
`timescale 1ns/10ps
`default_nettype none
module vfe_video_src #(
    parameter int LT = 24,
    parameter int FT = 8
) (
    // Clock and settings
    input wire logic double_rate_clock,
    input wire logic qpol,
    input wire logic hpol,
    input wire logic vpol,
    input wire logic fi_level,
    input wire logic hs_at_vs,
    input wire logic pix_en,
    input wire logic sync_en,
    // Pins
    output var logic pixel_qualifier_clock,
    output var logic field_id_input,
    output var vfe_pkg::vfe_pix_t pix_in,
    output var logic hsync_in,
    output var logic vsync_in,
    output var logic frame_tick
);
    import vfe_pkg::*;
    int px = 0;
    int ln = 0;
    int pos;
    logic q = 1'b0;
    initial
    begin
        {pixel_qualifier_clock, field_id_input, hsync_in, vsync_in, frame_tick} = '0;
        pix_in = '0;
    end
    // Off phase carries inverted data so a wrong qualifier phase shows
    always @(negedge double_rate_clock)
    begin
        q = ~q;
        pixel_qualifier_clock <= q;
        field_id_input <= fi_level;
        if (q == qpol)
        begin
            px = (px + 1) % LT;
            ln = (px == 0) ? (ln + 1) % FT : ln;
            pos = (ln * LT + px - (hs_at_vs ? 1 : 12) + LT * FT) % (LT * FT);
            frame_tick <= (pos == 0);
            // Released bus and syncs toggle instead of holding
            pix_in <= pix_en ? {px[7:0], ln[7:0]} : ~pix_in;
            hsync_in <= sync_en ? (px < 4) ^ hpol : ~hsync_in;
            vsync_in <= sync_en ? (pos < 2 * LT) ^ vpol : ~vsync_in;
        end
        else
            pix_in <= ~pix_in;
    end
endmodule
`default_nettype wire

// [video_front_end_sync_gen_test.sv]
// Self-checking bench of the video front end and sync generator.
// Assumes vfe_video_src on the pins; clocks 10 ns and 32 ns.
`timescale 1ns/10ps
`default_nettype none
module video_front_end_sync_gen_test;
    import vfe_pkg::*;
    localparam int LT = 24;
    localparam int FT = 8;
    localparam int HSW = 8;
    logic mclk = 0, drc = 0, reset_n = 0, fi = 0, hav = 0, coll = 0;
    vfe_cfg_t cfg;
    vfe_pix_t still_pixel, pix_in, pix_out, sample_data;
    logic pqc, fid, hs_in, vs_in, pix_oe, hsync_out, vsync_out, sync_oe, codec_oe;
    logic sample_valid, sample_active, field_top, start_pulse, top_stat, start_seen, tick;
    logic hprev = 1, vprev = 1, top_at;
    logic vlev[2];
    int hlen[2], vper[2], vhr[2];
    int fail_count = 0, n_tests = 0, cycles = 0, hrun = 0, vrun = 0, vact = 0, vlen = 0;
    int fp, n, fl, nl, nact, pulses, seens;
    integer seed = 32'he9e54943;
    vfe_pix_t got[$];

    initial forever #5 mclk = ~mclk;
    initial
    begin
        #7;
        forever #16 drc = ~drc;
    end

    vfe_front_end #(.HS_WIDTH(HSW)) uut (.mclk(mclk), .reset_n(reset_n),
        .double_rate_clock(drc), .cfg(cfg), .still_pixel(still_pixel),
        .pixel_qualifier_clock(pqc), .field_id_input(fid), .pix_in(pix_in),
        .pix_out(pix_out), .pix_oe(pix_oe), .hsync_in(hs_in), .vsync_in(vs_in),
        .hsync_out(hsync_out), .vsync_out(vsync_out), .sync_oe(sync_oe),
        .codec_output_enable(codec_oe), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_active(sample_active), .field_top(field_top),
        .start_pulse(start_pulse), .field_top_status(top_stat), .start_seen(start_seen));
    vfe_video_src #(.LT(LT), .FT(FT)) src (.double_rate_clock(drc),
        .qpol(cfg.qualifier_polarity), .hpol(cfg.line_sync_polarity),
        .vpol(cfg.frame_sync_polarity), .fi_level(fi), .hs_at_vs(hav), .pix_en(!pix_oe),
        .sync_en(!sync_oe), .pixel_qualifier_clock(pqc), .field_id_input(fid),
        .pix_in(pix_in), .hsync_in(hs_in), .vsync_in(vs_in), .frame_tick(tick));

    // ***************************************
    // Observers in the video and mclk domains
    // ***************************************
    always @(posedge drc)
    begin
        if (coll && sample_valid === 1'b1)
        begin
            got.push_back(sample_data);
            nact += (sample_active === 1'b1);
        end
        if (start_pulse === 1'b1)
        begin
            pulses++;
            top_at = field_top;
        end
        if (hsync_out !== hprev)
        begin
            hlen[hprev] = hrun;
            hrun = 1;
        end
        else
            hrun++;
        vact++;
        if (vsync_out !== vprev && vsync_out === ~cfg.frame_sync_polarity)
        begin
            {vper[1], vlev[1], vhr[1]} = {vper[0], vlev[0], vhr[0]};
            {vper[0], vlev[0], vhr[0]} = {vact, hsync_out, hrun};
            vact = 0;
        end
        if (vsync_out !== vprev && vsync_out === cfg.frame_sync_polarity)
            vlen = vrun;
        vrun = (vsync_out !== vprev) ? 1 : vrun + 1;
        hprev = hsync_out;
        vprev = vsync_out;
    end
    always @(posedge mclk)
    begin
        seens += (start_seen === 1'b1);
        cycles++;
        if (cycles == 95000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic frames(input int k);
        repeat (k) @(posedge tick);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ***************************************
    // Main sequence
    // ***************************************
    initial
    begin
        cfg = '0;
        cfg.top_field_sense = 1'b1;
        cfg.frame_line_total = FT;
        cfg.line_clock_total = LT;
        cfg.frame_sync_length = 2;
        cfg.line_sync_start = 4;
        still_pixel = '0;
        repeat (5) @(posedge mclk);
        check("hsync_out in reset", hsync_out, 1);
        check("vsync_out in reset", vsync_out, 1);
        check("enables in reset", {pix_oe, sync_oe, codec_oe, sample_valid}, 0);
        @(posedge mclk);
        reset_n <= 1;
        // Drive ownership per mode, sync source choice included
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            cfg.mode <= vfe_mode_t'(i[1:0]);
            cfg.internal_sync <= i[2];
            still_pixel <= vfe_pix_t'($random(seed));
            repeat (12) @(posedge mclk);
            check("codec_output_enable", codec_oe, i[0]);
            check("pix_oe", pix_oe, i[1:0] == 2);
            check("sync_oe", sync_oe, i[1] | (i[1:0] == 1 & i[2]));
            if (i[1:0] == 2)
                check("pix_out", pix_out, still_pixel);
        end
        @(posedge mclk);
        cfg.mode <= VFE_MOTION_COMP;
        cfg.internal_sync <= 0;
        $display("mode table done");
        // Windowed sampling over both sync edges and qualifier phases
        for (int i = 0; i < 4; i++)
        begin
            fp = 2 + {$random(seed)} % 6;
            n = 3 + {$random(seed)} % 10;
            fl = 1 + {$random(seed)} % 3;
            nl = 2 + {$random(seed)} % 3;
            @(posedge mclk);
            cfg.line_sync_polarity <= i[0];
            cfg.frame_sync_polarity <= i[0];
            cfg.qualifier_polarity <= i[1];
            cfg.first_pixel_offset <= fp;
            cfg.last_pixel_offset <= fp + n - 1;
            cfg.first_line_offset <= fl;
            cfg.last_line_offset <= fl + nl - 1;
            cfg.skip_pixels <= fp + 1;
            cfg.active_pixels <= 2;
            cfg.skip_lines <= fl;
            cfg.active_lines <= 1;
            frames(2);
            got.delete();
            nact = 0;
            coll = 1;
            frames(1);
            coll = 0;
            check("sample count", got.size(), n * nl);
            check("processed count", nact, 2);
            foreach (got[j])
            begin
                check("sample y", got[j].y, fp + j % n);
                check("sample uv", got[j].uv, fl + j / n);
            end
        end
        $display("sampling done");
        // Field identity from the pin, then from sync timing
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            cfg.line_sync_polarity <= 0;
            cfg.external_field_flag <= !i[2];
            cfg.top_field_sense <= i[0];
            fi <= i[1];
            hav <= i[1];
            frames(2);
            check("field_top", field_top, i[1] == i[0]);
            check("field_top_status", top_stat, i[1] == i[0]);
        end
        $display("field done");
        // Start only on a field of the requested type, once per request
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            cfg.external_field_flag <= 1;
            cfg.top_field_sense <= 1;
            fi <= i[1];
            cfg.first_field_type <= i[0];
            frames(1);
            pulses = 0;
            seens = 0;
            top_at = !i[0];
            @(posedge mclk);
            cfg.start_request <= 1;
            frames(3);
            check("start pulses", pulses, i[1] == i[0]);
            check("start seen", seens, i[1] == i[0]);
            if (i[1] == i[0])
                check("field at start", top_at, i[0]);
            @(posedge mclk);
            cfg.start_request <= 0;
        end
        $display("start done");
        // Generated syncs in both polarities
        for (int p = 0; p < 2; p++)
        begin
            @(posedge mclk);
            cfg.mode <= VFE_STILL_DECOMP;
            cfg.internal_sync <= 1;
            cfg.line_sync_polarity <= p[0];
            cfg.frame_sync_polarity <= p[0];
            frames(3);
            check("hsync active", hlen[!p], 2 * HSW);
            check("hsync line", hlen[0] + hlen[1], 2 * LT);
            check("vsync length", vlen, 4 * LT);
            check("frame length", vper[0] + vper[1], 2 * LT * FT);
            check("field edge kinds", vlev[0] ^ vlev[1], 1);
            for (int j = 0; j < 2; j++)
                check("vsync edge place", vhr[j], (vlev[j] === !p) ? HSW + 1 : LT - HSW + 1);
        end
        $display("generator done");
        wrap_up();
    end
endmodule
`default_nettype wire
